// ===== verilog/prc_top.sv
// power reduction clock gating, sleep enables and reset combiner
`timescale 1ns/1ns
module prc_top
#(
  parameter int TOUT_CYCLES = prc_pkg::TOUT_DEFAULT_CYC
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire prc_pkg::prc_fuse_t fuse_i,
  input wire logic sleep_i,
  input wire logic poweron_low_i,
  input wire logic brownout_low_i,
  input wire logic ext_reset_n_i,
  input wire logic watchdog_expire_i,
  input wire logic adc_conv_done_i,
  output logic [7:0] gated_clk_o,
  output logic [7:0] periph_access_o,
  output logic adc_enable_o,
  output logic adc_extended_o,
  output logic comparator_enable_o,
  output logic comparator_mux_enable_o,
  output logic ref_enable_o,
  output logic brownout_enable_o,
  output logic watchdog_run_o,
  output logic input_buffer_enable_o,
  output logic wake_buffer_enable_o,
  output logic main_osc_enable_o,
  output logic port_reset_n_o,
  output logic sys_reset_n_o
);
  import prc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [23:0] TOUT_BASE = 24'(TOUT_CYCLES);
  localparam logic [8:0] EXT_MIN = 9'(EXT_MIN_CYC);

  prc_state_t state_reg;
  prc_state_t state_next;
  logic [23:0] delay_cnt_reg;
  logic [23:0] tout_cyc;
  logic [8:0] ext_cnt_reg;
  logic ext_valid;
  logic bod_on;
  logic bor_raw;
  logic wdog_reset;
  logic src_any;
  logic running;
  logic port_clr_n;
  logic port_reset_reg;
  logic sys_reset_reg;
  logic [7:0] power_red_reg;
  logic [7:0] analog_ctrl_reg;
  logic [2:0] sleep_mode_reg;
  logic [7:0] rdata_reg;
  logic adc_ext_reg;
  logic adc_en_prev_reg;
  logic [7:0] gate_en_next;
  logic [7:0] gate_en_reg;
  logic [7:0] access_reg;
  logic io_run;
  logic adc_clk_run;
  logic shallow_sleep;
  logic timer_two_async;
  logic adc_on;
  logic comp_on;
  logic ref_on;
  logic osc_on;
  logic buf_on;
  logic adc_en_o_reg;
  logic comp_en_reg;
  logic comp_mux_reg;
  logic ref_en_reg;
  logic bod_en_reg;
  logic wdog_run_reg;
  logic buf_en_reg;
  logic osc_en_reg;

  // ****************************************
  // reset sources
  // ****************************************
  // detector enabled
  assign bod_on = (fuse_i.brownout_level_fuse != BOD_DISABLED);
  assign bor_raw = brownout_low_i & bod_on;
  assign wdog_reset = watchdog_expire_i & analog_ctrl_reg[AC_WDOG_RESET_MODE];
  assign src_any = poweron_low_i | bor_raw | ext_valid | wdog_reset;
  assign running = (state_reg == ST_RUN);

  // pin low filter
  // short glitches on the pin must not restart the core, so count the low time
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext_cnt_reg <= 9'h000;
    end
    else if (ext_reset_n_i)
    begin
      ext_cnt_reg <= 9'h000;
    end
    else if (ext_cnt_reg != EXT_MIN)
    begin
      ext_cnt_reg <= ext_cnt_reg + 9'h001;
    end
  end
  assign ext_valid = (ext_cnt_reg == EXT_MIN);

  // port reset without a clock
  // the clear path is combinational so a stopped clock cannot delay it
  assign port_clr_n = arst_n_i & ~poweron_low_i & ~bor_raw & ext_reset_n_i;
  always_ff @(posedge clk_i or negedge port_clr_n)
  begin
    if (!port_clr_n)
    begin
      port_reset_reg <= 1'b0;
    end
    else
    begin
      port_reset_reg <= ~wdog_reset & running;
    end
  end

  // ****************************************
  // internal reset stretch
  // ****************************************
  // fuse selected time-out
  // longer start-up fuse settings double the delay per step
  always_comb
  begin
    tout_cyc = TOUT_BASE << ({1'b0, fuse_i.startup_time_fuse} + {2'b00, fuse_i.clock_select_fuse[0]});
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD:
      begin
        state_next = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (delay_cnt_reg >= tout_cyc - 24'h000001)
        begin
          state_next = ST_RUN;
        end
      end
      ST_RUN:
      begin
        state_next = ST_RUN;
      end
      default:
      begin
        state_next = ST_HOLD;
      end
    endcase
    // any active source restarts the delay
    if (src_any)
    begin
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= ST_HOLD;
      delay_cnt_reg <= 24'h000000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next == ST_DELAY && state_reg == ST_DELAY)
      begin
        delay_cnt_reg <= delay_cnt_reg + 24'h000001;
      end
      else
      begin
        delay_cnt_reg <= 24'h000000;
      end
    end
  end

  // core released once the sequencer runs
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sys_reset_reg <= 1'b0;
    end
    else
    begin
      sys_reset_reg <= (state_next == ST_RUN);
    end
  end

  // ****************************************
  // register file
  // ****************************************
  // registers held at initial values during reset
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      power_red_reg <= POWER_RED_RESET;
      analog_ctrl_reg <= 8'h00;
      sleep_mode_reg <= MODE_IDLE;
    end
    else if (!running)
    begin
      power_red_reg <= POWER_RED_RESET;
      analog_ctrl_reg <= 8'h00;
      sleep_mode_reg <= MODE_IDLE;
    end
    else if (wr_i)
    begin
      case (addr_i)
        ADDR_POWER_RED:
        begin
          power_red_reg <= wdata_i & POWER_RED_WMASK;
          // spi gate refused while debug fuse is on
          if (fuse_i.debug_enable_fuse)
          begin
            power_red_reg[GATE_SERIAL_PERIPHERAL] <= 1'b0;
          end
        end
        ADDR_ANALOG_CTRL:
        begin
          analog_ctrl_reg <= {1'b0, wdata_i[6:0]};
        end
        ADDR_SLEEP_CTRL:
        begin
          sleep_mode_reg <= wdata_i[2:0];
        end
        default:
        begin
          sleep_mode_reg <= sleep_mode_reg;
        end
      endcase
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_reg <= 8'h00;
    end
    else if (rd_i)
    begin
      case (addr_i)
        ADDR_POWER_RED: rdata_reg <= power_red_reg;
        ADDR_ANALOG_CTRL: rdata_reg <= analog_ctrl_reg;
        ADDR_SLEEP_CTRL: rdata_reg <= {5'h00, sleep_mode_reg};
        ADDR_STATUS: rdata_reg <= {4'h0, buf_en_reg, osc_en_reg, adc_ext_reg, ref_en_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
    else
    begin
      rdata_reg <= 8'h00;
    end
  end

  // ****************************************
  // sleep decode
  // ****************************************
  assign shallow_sleep = (sleep_mode_reg == MODE_IDLE) | (sleep_mode_reg == MODE_ADC_NOISE);
  assign io_run = ~sleep_i | (sleep_mode_reg == MODE_IDLE);
  assign adc_clk_run = ~sleep_i | shallow_sleep;
  assign timer_two_async = analog_ctrl_reg[AC_TIMER_TWO_ASYNC];

  always_comb
  begin
    // adc stays enabled in any sleep mode
    adc_on = analog_ctrl_reg[AC_ADC_ENABLE] & ~power_red_reg[GATE_CONVERTER];
    comp_on = ~analog_ctrl_reg[AC_COMP_DISABLE] & (~sleep_i | shallow_sleep);
    // bandgap use keeps reference regardless of sleep
    ref_on = bod_on | adc_on;
    if (analog_ctrl_reg[AC_COMP_BANDGAP] & ~analog_ctrl_reg[AC_COMP_DISABLE])
    begin
      ref_on = 1'b1;
    end
    // buffers off when io and adc clocks stop
    buf_on = io_run | adc_clk_run;
    osc_on = ~sleep_i | shallow_sleep | (sleep_mode_reg == MODE_STANDBY)
             | fuse_i.debug_enable_fuse
             | ((sleep_mode_reg == MODE_POWER_SAVE) & ~timer_two_async);
  end

  // registered enables toward the analogue helpers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      adc_en_o_reg <= 1'b0;
      comp_en_reg <= 1'b0;
      comp_mux_reg <= 1'b0;
      ref_en_reg <= 1'b0;
      bod_en_reg <= 1'b0;
      wdog_run_reg <= 1'b0;
      buf_en_reg <= 1'b1;
      osc_en_reg <= 1'b1;
    end
    else
    begin
      adc_en_o_reg <= adc_on;
      comp_en_reg <= comp_on;
      // comparator loses the adc mux while the converter power reduction bit is set
      comp_mux_reg <= analog_ctrl_reg[AC_COMP_MUX] & ~power_red_reg[GATE_CONVERTER];
      ref_en_reg <= ref_on;
      bod_en_reg <= bod_on;
      wdog_run_reg <= analog_ctrl_reg[AC_WDOG_ENABLE];
      buf_en_reg <= buf_on;
      osc_en_reg <= osc_on;
    end
  end

  // extended conversion after off and on
  // set wins over the clear by a completed conversion in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      adc_en_prev_reg <= 1'b0;
      adc_ext_reg <= 1'b1;
    end
    else
    begin
      adc_en_prev_reg <= adc_on;
      if (adc_on & ~adc_en_prev_reg)
      begin
        adc_ext_reg <= 1'b1;
      end
      else if (adc_conv_done_i)
      begin
        adc_ext_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // peripheral clock gates
  // ****************************************
  always_comb
  begin
    gate_en_next = 8'h00;
    gate_en_next[GATE_TWO_WIRE_UNIT] = io_run & ~power_red_reg[GATE_TWO_WIRE_UNIT];
    // timer two gate only in synchronous mode
    gate_en_next[GATE_TIMER_TWO] = (~power_red_reg[GATE_TIMER_TWO] | timer_two_async)
      & (io_run | ~sleep_i | (sleep_mode_reg == MODE_ADC_NOISE)
         | (sleep_mode_reg == MODE_POWER_SAVE));
    gate_en_next[GATE_TIMER_ZERO] = io_run & ~power_red_reg[GATE_TIMER_ZERO];
    gate_en_next[GATE_TIMER_ONE] = io_run & ~power_red_reg[GATE_TIMER_ONE];
    gate_en_next[GATE_SERIAL_PERIPHERAL] = io_run & ~power_red_reg[GATE_SERIAL_PERIPHERAL];
    gate_en_next[GATE_SERIAL_PORT] = io_run & ~power_red_reg[GATE_SERIAL_PORT];
    gate_en_next[GATE_CONVERTER] = adc_clk_run & ~power_red_reg[GATE_CONVERTER];
  end

  // the enable is retimed on the falling edge, so the and-gate only sees it
  // change while the clock is low; the unused reserved slot is off from the first falling edge after reset
  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g++)
    begin : gen_gate
      always_ff @(negedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          gate_en_reg[g] <= 1'b1;
        end
        else
        begin
          gate_en_reg[g] <= gate_en_next[g];
        end
      end
      // stopped clock freezes state, so restart resumes it
      assign gated_clk_o[g] = clk_i & gate_en_reg[g];
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          access_reg[g] <= 1'b0;
        end
        else
        begin
          access_reg[g] <= gate_en_next[g] & gate_en_reg[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_o = rdata_reg;
  assign periph_access_o = access_reg;
  assign adc_enable_o = adc_en_o_reg;
  assign adc_extended_o = adc_ext_reg;
  assign comparator_enable_o = comp_en_reg;
  assign comparator_mux_enable_o = comp_mux_reg;
  assign ref_enable_o = ref_en_reg;
  assign brownout_enable_o = bod_en_reg;
  assign watchdog_run_o = wdog_run_reg;
  assign input_buffer_enable_o = buf_en_reg;
  assign wake_buffer_enable_o = port_reset_reg | ~port_reset_reg;
  assign main_osc_enable_o = osc_en_reg;
  assign port_reset_n_o = port_reset_reg;
  assign sys_reset_n_o = sys_reset_reg;
endmodule

// ===== verilog/prc_pkg.sv
// constants, field layout and types of the power reduction and reset control block
package prc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_POWER_RED = 8'h00;
  localparam logic [7:0] ADDR_ANALOG_CTRL = 8'h01;
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] POWER_RED_RESET = 8'h00;
  localparam logic [7:0] POWER_RED_WMASK = 8'hEF;
  // power reduction bit positions, also the gated clock index
  localparam int GATE_CONVERTER = 0;
  localparam int GATE_SERIAL_PORT = 1;
  localparam int GATE_SERIAL_PERIPHERAL = 2;
  localparam int GATE_TIMER_ONE = 3;
  localparam int GATE_TIMER_ZERO = 5;
  localparam int GATE_TIMER_TWO = 6;
  localparam int GATE_TWO_WIRE_UNIT = 7;
  localparam int NUM_GATES = 8;
  // analog control bit positions
  localparam int AC_ADC_ENABLE = 0;
  localparam int AC_COMP_DISABLE = 1;
  localparam int AC_COMP_BANDGAP = 2;
  localparam int AC_COMP_MUX = 3;
  localparam int AC_TIMER_TWO_ASYNC = 4;
  localparam int AC_WDOG_ENABLE = 5;
  localparam int AC_WDOG_RESET_MODE = 6;
  // sleep mode encodings, and the detector-off fuse level
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NOISE = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
  localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] BOD_DISABLED = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int EXT_MIN_PULSE_NS = 2000;
  localparam int EXT_MIN_CYC = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOUT_MS = 4;
  localparam int TOUT_DEFAULT_CYC = TOUT_MS * 1000000 / CLK_PERIOD_NS;
  // fuse bundle
  typedef struct packed {
    logic [2:0] brownout_level_fuse;
    logic [1:0] startup_time_fuse;
    logic [3:0] clock_select_fuse;
    logic debug_enable_fuse;
  } prc_fuse_t;
  // internal reset sequencer, gray along hold, delay, run
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b11
  } prc_state_t;
endpackage

// ===== verification/prc_monitor.sv
// assertion checker for the power reduction and reset control block
`timescale 1ns/1ns
module prc_monitor
#(
  parameter int TOUT_CYCLES = prc_pkg::TOUT_DEFAULT_CYC
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire prc_pkg::prc_fuse_t fuse_i,
  input wire logic sleep_i,
  input wire logic poweron_low_i,
  input wire logic brownout_low_i,
  input wire logic ext_reset_n_i,
  input wire logic [7:0] periph_access_o,
  input wire logic brownout_enable_o,
  input wire logic ref_enable_o,
  input wire logic main_osc_enable_o,
  input wire logic port_reset_n_o,
  input wire logic sys_reset_n_o
);
  import prc_pkg::*;
  // ****************************************
  // helper counters
  // ****************************************
  logic [31:0] low_cnt_reg;
  logic [15:0] ext_cnt_reg;
  logic [31:0] tout;
  // shift held in three bits so the largest fuse sum does not wrap
  assign tout = TOUT_CYCLES << ({1'b0, fuse_i.startup_time_fuse} + {2'h0, fuse_i.clock_select_fuse[0]});
  // cycles with internal reset low, and with the reset pin low
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      low_cnt_reg <= 32'h0;
      ext_cnt_reg <= 16'h0;
    end
    else
    begin
      low_cnt_reg <= sys_reset_n_o ? 32'h0 : low_cnt_reg + 32'h1;
      ext_cnt_reg <= ext_reset_n_i ? 16'h0 : ext_cnt_reg + 16'h1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence pr_write;
    wr_i && addr_i == ADDR_POWER_RED && sys_reset_n_o && !sleep_i;
  endsequence
  sequence pr_read;
    rd_i && addr_i == ADDR_POWER_RED;
  endsequence
  reserved_read_a:
    assert property (pr_read |=> rdata_o[4] == 1'b0) else $error("reserved bit read as one");
  access_follows_a:
    assert property (pr_write |-> ##2 (!sys_reset_n_o
      || (periph_access_o & 8'hAB) == (~$past(wdata_i, 2) & 8'hAB)))
      else $error("peripheral access does not follow reduction bits");
  delay_stretch_a:
    assert property ($rose(sys_reset_n_o) |-> low_cnt_reg >= tout)
      else $error("internal reset released before time-out");
  port_reset_async_a:
    assert property (poweron_low_i || !ext_reset_n_i |-> !port_reset_n_o)
      else $error("port reset not active with a reset source");
  brownout_reset_a:
    assert property (brownout_low_i && fuse_i.brownout_level_fuse != BOD_DISABLED
      |-> !port_reset_n_o) else $error("brown-out did not reset ports");
  poweron_hold_a:
    assert property (poweron_low_i |=> !sys_reset_n_o) else $error("power-on did not reset core");
  ext_pulse_a:
    assert property (ext_cnt_reg == EXT_MIN_CYC + 4 |-> !sys_reset_n_o)
      else $error("long pin pulse did not reset core");
  bod_enabled_a:
    assert property (sys_reset_n_o && fuse_i.brownout_level_fuse != BOD_DISABLED
      |-> brownout_enable_o && ref_enable_o) else $error("detector or reference off");
  debug_osc_a:
    assert property (sys_reset_n_o && fuse_i.debug_enable_fuse |-> main_osc_enable_o)
      else $error("main oscillator off with debug fuse");
endmodule
bind prc_top prc_monitor #(.TOUT_CYCLES(TOUT_CYCLES)) u_mon (.*);

// ===== verification/tb.sv
// self-checking testbench for the power reduction and reset control block
`timescale 1ns/1ns
module tb;
  import prc_pkg::*;
  localparam int TB_TOUT = 8;
  logic clk_i = 1'b0;
  logic arst_n_i, wr_i, rd_i, sleep_i, poweron_low_i, brownout_low_i;
  logic ext_reset_n_i, watchdog_expire_i, adc_conv_done_i;
  logic [7:0] addr_i, wdata_i, rdata_o, gated_clk_o, periph_access_o;
  prc_fuse_t fuse_i;
  logic adc_enable_o, adc_extended_o, comparator_enable_o, comparator_mux_enable_o;
  logic ref_enable_o, brownout_enable_o, watchdog_run_o, input_buffer_enable_o;
  logic wake_buffer_enable_o, main_osc_enable_o, port_reset_n_o, sys_reset_n_o;
  logic [2:0] modes [5] = '{MODE_IDLE, MODE_ADC_NOISE, MODE_POWER_DOWN, MODE_POWER_SAVE,
    MODE_STANDBY};
  integer seed = 32'h2B7B41C3;
  int fails = 0;
  int checked = 0;
  int n;
  logic [7:0] d;
  logic [7:0] w;
  // ****************************************
  // clock, design and helpers
  // ****************************************
  always #4 clk_i = ~clk_i;
  // short time-out keeps the reset stretch cheap to simulate
  prc_top #(.TOUT_CYCLES(TB_TOUT)) u_dut (.*);
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  // sample at the falling edge so registered outputs have landed
  task automatic settle(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask
  task automatic wait_run(output int c);
    c = 0;
    while (sys_reset_n_o !== 1'b1 && c < 3000)
    begin
      @(negedge clk_i);
      c++;
    end
    chk_bit(sys_reset_n_o, 1'b1);
  endtask
  task automatic hard_reset(input prc_fuse_t f);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    fuse_i <= f;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait_run(n);
    chk_bit(n >= (TB_TOUT << (int'(f.startup_time_fuse) + int'(f.clock_select_fuse[0]))), 1'b1);
  endtask
  task automatic sleep_in(input logic [2:0] m);
    wr(ADDR_SLEEP_CTRL, {5'h00, m});
    @(posedge clk_i);
    sleep_i <= 1'b1;
    settle(2);
  endtask
  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    {wr_i, rd_i, sleep_i, poweron_low_i, brownout_low_i, watchdog_expire_i} = 6'h00;
    {adc_conv_done_i, arst_n_i, ext_reset_n_i, addr_i, wdata_i} = 19'h00001 << 16;
    fuse_i = 10'h300;
    hard_reset(10'h300);
    rd(ADDR_POWER_RED, d);
    chk_reg(d, POWER_RED_RESET);
    rd(ADDR_STATUS, d);
    chk_reg(d, 8'h0F);
    rd(8'h20, d);
    chk_reg(d, 8'h00);
    // corner values first, then random patterns
    for (int i = 0; i < 12; i++)
    begin
      w = (i == 0) ? 8'hFF : (i == 1) ? 8'h10 : 8'($random(seed));
      wr(ADDR_POWER_RED, w);
      settle(1);
      chk_reg(periph_access_o & 8'hEF, ~w & 8'hEF);
      // in the high phase a running gated clock is high, a stopped one low
      @(posedge clk_i);
      #1;
      chk_reg(gated_clk_o & 8'hEF, ~w & 8'hEF);
      rd(ADDR_POWER_RED, d);
      chk_reg(d, w & POWER_RED_WMASK);
    end
    wr(ADDR_ANALOG_CTRL, 8'h10);
    wr(ADDR_POWER_RED, 8'h40);
    settle(1);
    chk_bit(periph_access_o[GATE_TIMER_TWO], 1'b1);
    wr(ADDR_ANALOG_CTRL, 8'h08);
    settle(2);
    chk_bit(periph_access_o[GATE_TIMER_TWO], 1'b0);
    for (int i = 1; i >= 0; i--)
    begin
      wr(ADDR_POWER_RED, 8'(i));
      settle(1);
      chk_bit(comparator_mux_enable_o, i == 0);
    end
    wr(ADDR_ANALOG_CTRL, 8'h01);
    @(posedge clk_i);
    adc_conv_done_i <= 1'b1;
    @(posedge clk_i);
    adc_conv_done_i <= 1'b0;
    settle(1);
    chk_bit(adc_extended_o, 1'b0);
    wr(ADDR_ANALOG_CTRL, 8'h00);
    wr(ADDR_ANALOG_CTRL, 8'h21);
    settle(1);
    chk_bit(adc_extended_o, 1'b1);
    foreach (modes[i])
    begin
      sleep_in(modes[i]);
      chk_bit(comparator_enable_o, modes[i] < 3'h2);
      chk_bit(input_buffer_enable_o, modes[i] < 3'h2);
      chk_bit(adc_enable_o & watchdog_run_o, 1'b1);
      chk_bit(wake_buffer_enable_o, 1'b1);
      @(posedge clk_i);
      sleep_i <= 1'b0;
    end
    wr(ADDR_POWER_RED, 8'h02);
    wr(ADDR_ANALOG_CTRL, 8'h60);
    @(posedge clk_i);
    watchdog_expire_i <= 1'b1;
    @(posedge clk_i);
    watchdog_expire_i <= 1'b0;
    settle(2);
    chk_bit(sys_reset_n_o | port_reset_n_o, 1'b0);
    wait_run(n);
    rd(ADDR_POWER_RED, d);
    chk_reg(d, POWER_RED_RESET);
    // a short pin pulse must not reach the core, a long one must
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      ext_reset_n_i <= 1'b0;
      settle(0);
      chk_bit(port_reset_n_o, 1'b0);
      repeat (k ? EXT_MIN_CYC + 10 : 5) @(posedge clk_i);
      settle(0);
      chk_bit(sys_reset_n_o, k == 0);
      @(posedge clk_i);
      ext_reset_n_i <= 1'b1;
      wait_run(n);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      poweron_low_i <= (k == 0);
      brownout_low_i <= (k == 1);
      settle(1);
      chk_bit(port_reset_n_o | sys_reset_n_o, 1'b0);
      @(posedge clk_i);
      {poweron_low_i, brownout_low_i} <= 2'h0;
      wait_run(n);
      chk_bit(n >= TB_TOUT, 1'b1);
    end
    // detector off, debug on, doubled start-up delay
    hard_reset(10'h3A1);
    @(posedge clk_i);
    brownout_low_i <= 1'b1;
    settle(1);
    chk_bit(port_reset_n_o & sys_reset_n_o, 1'b1);
    @(posedge clk_i);
    brownout_low_i <= 1'b0;
    settle(1);
    chk_bit(brownout_enable_o | ref_enable_o, 1'b0);
    wr(ADDR_ANALOG_CTRL, 8'h04);
    settle(1);
    chk_bit(ref_enable_o, 1'b1);
    wr(ADDR_POWER_RED, 8'h04);
    rd(ADDR_POWER_RED, d);
    chk_reg(d, 8'h00);
    sleep_in(MODE_POWER_DOWN);
    chk_bit(main_osc_enable_o, 1'b1);
    tally_and_finish;
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    tally_and_finish;
  end
endmodule
